// ---- src/tmc_mode_ctrl.v ----
// Overview of operation
// - Pin A enabled in dual-input capture: each A edge loads counter one all-ones.
// - Other modes: pin A enable makes pin A the PWM output.
// - Pin B enabled: B edge presets counter one in mode 2, two in mode 4.
// - Pin B enable does nothing in modes 1, 1a and 3.
// - Output value bit mirrors PWM level on pin A; software reads/writes it.
// - Software write wins over a simultaneous hardware toggle.
// - Output value bit ignored while pin A is input or unit disabled.
// - Unit enable clear stops all counter clocks.
// - Disabled unit ignores writes to counters, capture/reload, pending bits.
// - Disabled unit resets prescaler and pending bits, pin A becomes input.
// - Pulse-train enable with mode 00b selects mode 1a.
// - Pulse-train enable ignored for any other mode value.
// - Mode field: 00 PWM/pulse train, 01 dual capture, 10 dual, 11 single.
// - Edge polarity bit per pin: 0 falling, 1 rising.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_defines.vh"

module tmc_mode_ctrl (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Timer pins
    input wire timer_pin_a_in,
    output reg timer_pin_a_out,
    output reg timer_pin_a_oe,
    input wire timer_pin_b_in,
    // PWM level from counter logic, toggle request
    input wire pwm_level,
    input wire pwm_toggle,
    // Write requests from software to gated registers
    input wire cnt_wr_req,
    input wire crr_wr_req,
    input wire pnd_wr_req,
    // Controls to the counter logic
    output reg counter_clk_en,
    output reg prescaler_clr,
    output reg pending_clr,
    output reg cnt_wr_allow,
    output reg crr_wr_allow,
    output reg pnd_wr_allow,
    output reg [2:0] sub_mode,
    output reg counter_one_preset,
    output reg counter_two_preset
);

// ----------------------------------------------------------------
// Register
// ----------------------------------------------------------------
// Field map of the mode control word:
//   1:0 mode select, 2 pin A edge, 3 pin B edge,
//   4 pin A function enable, 5 pin B preset enable,
//   6 pin A output value, 7 unit enable, 8 pulse-train enable.
// Bits 31:9 are not stored and read back as zero.
reg [`TMC_CTRL_MSB:0] ctrl_r;
reg [`TMC_CTRL_MSB:0] ctrl_nxt;
wire edge_a;
wire edge_b;
wire [1:0] mode;
wire unit_en;
wire aen;
wire ben;
wire pten;
wire wr_hit;
wire acc;
wire pwm_drive;
wire mode_dualcap;
wire mode_singlecap;
wire setup;
wire rd_setup;
wire hw_toggle;
// Per-pin vectors, index 0 is pin A and index 1 is pin B
wire [1:0] pin_in_w;
wire [1:0] rising_w;
wire [1:0] edge_w;
wire preset_one_nxt;
wire preset_two_nxt;
reg [2:0] sub_mode_nxt;
genvar g;

assign mode = ctrl_r[`TMC_MDSEL_MSB:`TMC_MDSEL_LSB];
assign unit_en = ctrl_r[`TMC_EN_BIT];
assign aen = ctrl_r[`TMC_AEN_BIT];
assign ben = ctrl_r[`TMC_BEN_BIT];
assign pten = ctrl_r[`TMC_PTEN_BIT];
assign mode_dualcap = (mode == `TMC_MODE_DUALCAP);
assign mode_singlecap = (mode == `TMC_MODE_SINGLECAP);
assign acc = psel & penable;
assign setup = psel & ~penable;
assign wr_hit = acc & pwrite & (paddr == `TMC_ADDR_MODE_CTRL);
assign rd_setup = setup & ~pwrite & (paddr == `TMC_ADDR_MODE_CTRL);
// Pin A drives only as PWM output in an enabled unit
assign pwm_drive = unit_en & aen & ~mode_dualcap;
// Toggle requests are dropped while the pin is not a PWM output
assign hw_toggle = pwm_drive & pwm_toggle;

// ----------------------------------------------------------------
// Pin edge detection
// ----------------------------------------------------------------
// A pin edge reaches the preset outputs four clocks later; pulses on
// a pin narrower than one clock may be missed
assign pin_in_w[0] = timer_pin_a_in;
assign pin_in_w[1] = timer_pin_b_in;
assign rising_w[0] = ctrl_r[`TMC_AEDG_BIT];
assign rising_w[1] = ctrl_r[`TMC_BEDG_BIT];

generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_pin
        tmc_edge_detect u_edge (
            .pclk(pclk),
            .presetn(presetn),
            .pin_in(pin_in_w[g]),
            .rising_sel(rising_w[g]),
            .edge_evt(edge_w[g])
        );
    end
endgenerate

assign edge_a = edge_w[0];
assign edge_b = edge_w[1];

// ----------------------------------------------------------------
// Next control value
// ----------------------------------------------------------------
always @*
begin
    ctrl_nxt = ctrl_r;
    // Hardware tracks the pin level only while it really drives PWM
    if (hw_toggle)
        ctrl_nxt[`TMC_AOUT_BIT] = ~ctrl_r[`TMC_AOUT_BIT];
    // Full-word write comes last so it overrides the toggle
    if (wr_hit)
        ctrl_nxt = pwdata[`TMC_CTRL_MSB:0];
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        ctrl_r <= `TMC_CTRL_RESET;
    else
        ctrl_r <= ctrl_nxt;
end

// ----------------------------------------------------------------
// APB response, zero wait states
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        // Ready is raised in the setup cycle so access completes at once
        pready <= setup;
        pslverr <= setup & (paddr != `TMC_ADDR_MODE_CTRL);
        // Read data is the value the register holds after this edge
        if (rd_setup)
            prdata <= {23'h000000, ctrl_nxt};
        else
            prdata <= 32'h00000000;
    end
end

// ----------------------------------------------------------------
// Pin A drive
// ----------------------------------------------------------------
// The pin follows the counter's PWM level rather than the stored bit,
// so a software write to the bit never glitches the pin
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        timer_pin_a_out <= 1'b0;
        timer_pin_a_oe <= 1'b0;
    end
    else
    begin
        timer_pin_a_oe <= pwm_drive;
        // Pin value follows the PWM level; zero when not driving
        timer_pin_a_out <= pwm_drive & pwm_level;
    end
end

// ----------------------------------------------------------------
// Unit enable
// ----------------------------------------------------------------
// Prescaler and pending bits stay cleared from reset until enabled
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        counter_clk_en <= 1'b0;
        prescaler_clr <= 1'b1;
        pending_clr <= 1'b1;
    end
    else
    begin
        counter_clk_en <= unit_en;
        prescaler_clr <= ~unit_en;
        pending_clr <= ~unit_en;
    end
end

// ----------------------------------------------------------------
// Write gating
// ----------------------------------------------------------------
// The allow lines lag the request by one cycle, so the counter logic
// must hold its write data and address for that cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cnt_wr_allow <= 1'b0;
        crr_wr_allow <= 1'b0;
        pnd_wr_allow <= 1'b0;
    end
    else
    begin
        cnt_wr_allow <= unit_en & cnt_wr_req;
        crr_wr_allow <= unit_en & crr_wr_req;
        pnd_wr_allow <= unit_en & pnd_wr_req;
    end
end

// ----------------------------------------------------------------
// Sub-mode decode
// ----------------------------------------------------------------
always @*
begin
    sub_mode_nxt = `TMC_SUB_1;
    case (mode)
        `TMC_MODE_PWM:
            sub_mode_nxt = pten ? `TMC_SUB_1A : `TMC_SUB_1;
        `TMC_MODE_DUALCAP:
            sub_mode_nxt = `TMC_SUB_2;
        `TMC_MODE_DUALCNT:
            sub_mode_nxt = `TMC_SUB_3;
        `TMC_MODE_SINGLECAP:
            sub_mode_nxt = `TMC_SUB_4;
        default:
            sub_mode_nxt = `TMC_SUB_1;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        sub_mode <= `TMC_SUB_1;
    else
        sub_mode <= sub_mode_nxt;
end

// ----------------------------------------------------------------
// Counter presets
// ----------------------------------------------------------------
// Presets need a running unit since counter clocks are gated
assign preset_one_nxt = unit_en & mode_dualcap &
    ((aen & edge_a) | (ben & edge_b));
assign preset_two_nxt = unit_en & mode_singlecap & ben & edge_b;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        counter_one_preset <= 1'b0;
        counter_two_preset <= 1'b0;
    end
    else
    begin
        counter_one_preset <= preset_one_nxt;
        counter_two_preset <= preset_two_nxt;
    end
end

endmodule

`default_nettype wire

// ---- src/tmc_defines.vh ----
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// Register byte address on APB
`define TMC_ADDR_MODE_CTRL 12'h018

// Field positions of the mode control register
`define TMC_MDSEL_LSB 0
`define TMC_MDSEL_MSB 1
`define TMC_AEDG_BIT 2
`define TMC_BEDG_BIT 3
`define TMC_AEN_BIT 4
`define TMC_BEN_BIT 5
`define TMC_AOUT_BIT 6
`define TMC_EN_BIT 7
`define TMC_PTEN_BIT 8
`define TMC_CTRL_MSB 8

// Reset value of the implemented control bits
`define TMC_CTRL_RESET 9'h000

// Mode select encodings
`define TMC_MODE_PWM 2'h0
`define TMC_MODE_DUALCAP 2'h1
`define TMC_MODE_DUALCNT 2'h2
`define TMC_MODE_SINGLECAP 2'h3

// Sub-mode codes reported to counter logic
`define TMC_SUB_1 3'h0
`define TMC_SUB_1A 3'h1
`define TMC_SUB_2 3'h2
`define TMC_SUB_3 3'h3
`define TMC_SUB_4 3'h4

`endif

// ---- src/tmc_edge_detect.v ----
`timescale 1ns/1ns
`default_nettype none

// Synchroniser plus selectable-edge detector for one timer pin
module tmc_edge_detect (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Pin and edge selection
    input wire pin_in,
    input wire rising_sel,
    // One-cycle event
    output reg edge_evt
);

reg sync1_r;
reg sync2_r;
reg last_r;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
        last_r <= 1'b0;
        edge_evt <= 1'b0;
    end
    else
    begin
        sync1_r <= pin_in;
        sync2_r <= sync1_r;
        last_r <= sync2_r;
        edge_evt <= rising_sel ? (sync2_r & ~last_r) : (~sync2_r & last_r);
    end
end

endmodule

`default_nettype wire

// ---- verif/tmc_mode_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmc_mode_ctrl_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic timer_pin_a_out,
    input wire logic timer_pin_a_oe,
    input wire logic timer_pin_b_in,
    input wire logic pwm_level,
    input wire logic cnt_wr_req,
    input wire logic cnt_wr_allow,
    input wire logic crr_wr_req,
    input wire logic crr_wr_allow,
    input wire logic pnd_wr_req,
    input wire logic pnd_wr_allow,
    input wire logic counter_clk_en,
    input wire logic prescaler_clr,
    input wire logic pending_clr,
    input wire logic [2:0] sub_mode,
    input wire logic counter_one_preset,
    input wire logic counter_two_preset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------
    // Pin B edge seen two to five samples back
    // ------------------------------------------------
    sequence b_moved;
        $past(timer_pin_b_in, 5) != $past(timer_pin_b_in, 2);
    endsequence
    a_clk_stop: assert property (counter_clk_en != prescaler_clr)
        else $error("counter clock and prescaler clear disagree");
    a_pend_clr: assert property (pending_clr == prescaler_clr)
        else $error("pending clear differs from prescaler clear");
    a_pin_input: assert property (!counter_clk_en |-> !timer_pin_a_oe)
        else $error("pin A driven while unit disabled");
    a_dualcap_no_pwm: assert property (sub_mode == 3'h2 |-> !timer_pin_a_oe)
        else $error("pin A driven in dual capture mode");
    a_pin_mirror: assert property (timer_pin_a_oe &&
        $past(timer_pin_a_oe) |-> timer_pin_a_out == $past(pwm_level))
        else $error("pin A level does not follow PWM level");
    a_wr_gate: assert property (cnt_wr_allow ==
        ($past(cnt_wr_req) && counter_clk_en))
        else $error("counter write allowed while disabled");
    a_crr_gate: assert property (crr_wr_allow ==
        ($past(crr_wr_req) && counter_clk_en))
        else $error("capture reload write allowed while disabled");
    a_pnd_gate: assert property (pnd_wr_allow ==
        ($past(pnd_wr_req) && counter_clk_en))
        else $error("pending write allowed while disabled");
    a_one_gate: assert property (counter_one_preset |->
        counter_clk_en && sub_mode == 3'h2 ##1 !counter_one_preset)
        else $error("counter one preset outside dual capture");
    a_two_gate: assert property (counter_two_preset |->
        sub_mode == 3'h4 ##0 b_moved ##1 !counter_two_preset)
        else $error("counter two preset without pin B edge");
endmodule
bind tmc_mode_ctrl tmc_mode_ctrl_props tmc_mode_ctrl_props_inst (
    .pclk(pclk),
    .presetn(presetn),
    .timer_pin_a_out(timer_pin_a_out),
    .timer_pin_a_oe(timer_pin_a_oe),
    .timer_pin_b_in(timer_pin_b_in),
    .pwm_level(pwm_level),
    .cnt_wr_req(cnt_wr_req),
    .cnt_wr_allow(cnt_wr_allow),
    .crr_wr_req(crr_wr_req),
    .crr_wr_allow(crr_wr_allow),
    .pnd_wr_req(pnd_wr_req),
    .pnd_wr_allow(pnd_wr_allow),
    .counter_clk_en(counter_clk_en),
    .prescaler_clr(prescaler_clr),
    .pending_clr(pending_clr),
    .sub_mode(sub_mode),
    .counter_one_preset(counter_one_preset),
    .counter_two_preset(counter_two_preset)
);
`default_nettype wire

// ---- verif/tmc_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmc_pin_model (
    // Clock and edge requests
    input wire logic pclk,
    input wire logic flip_a,
    input wire logic flip_b,
    // Block drive of pin A
    input wire logic a_oe,
    input wire logic a_out,
    // Pin levels
    output logic pin_a,
    output logic pin_b
);
    logic a_r = 1'h0;
    logic b_r = 1'h0;
    always @(posedge pclk)
    begin
        a_r <= a_r ^ flip_a;
        b_r <= b_r ^ flip_b;
    end
    // Block wins the wire while it drives
    assign pin_a = a_oe ? a_out : a_r;
    assign pin_b = b_r;
endmodule
`default_nettype wire

// ---- verif/test_tmc_mode_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_tmc_mode_ctrl;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pwm_level = 1'h0, pwm_toggle = 1'h0;
    logic fa = 1'h0, fb = 1'h0;
    logic cnt_wr_req = 1'h0, crr_wr_req = 1'h0, pnd_wr_req = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, timer_pin_a_in, timer_pin_a_out, timer_pin_a_oe;
    logic timer_pin_b_in, counter_clk_en, prescaler_clr, pending_clr;
    logic cnt_wr_allow, crr_wr_allow, pnd_wr_allow, counter_one_preset;
    logic counter_two_preset;
    logic [2:0] sub_mode;
    logic [7:0] rnd = 8'h35;
    logic [8:0] cfg [4] = '{9'h0bd, 9'h0b3, 9'h0b2, 9'h03d};
    logic [3:0] ep [4] = '{4'h8, 4'h1, 4'h0, 4'h0};
    logic [32:0] exq [$];
    int n_errors = 0, samples_checked = 0, cyc = 0, n1 = 0, n2 = 0;
    always #25 pclk = ~pclk;
    tmc_mode_ctrl tmc_mode_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_pin_a_in(timer_pin_a_in),
        .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe(timer_pin_a_oe),
        .timer_pin_b_in(timer_pin_b_in), .pwm_level(pwm_level),
        .pwm_toggle(pwm_toggle), .cnt_wr_req(cnt_wr_req),
        .crr_wr_req(crr_wr_req), .pnd_wr_req(pnd_wr_req),
        .counter_clk_en(counter_clk_en), .prescaler_clr(prescaler_clr),
        .pending_clr(pending_clr), .cnt_wr_allow(cnt_wr_allow),
        .crr_wr_allow(crr_wr_allow), .pnd_wr_allow(pnd_wr_allow),
        .sub_mode(sub_mode), .counter_one_preset(counter_one_preset),
        .counter_two_preset(counter_two_preset));
    tmc_pin_model tmc_pin_model_inst (.pclk(pclk), .flip_a(fa), .flip_b(fb),
        .a_oe(timer_pin_a_oe), .a_out(timer_pin_a_out),
        .pin_a(timer_pin_a_in), .pin_b(timer_pin_b_in));
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    function automatic [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input [32:0] got, input [32:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Note goes on the queue before the access edge that the monitor uses
    task automatic apb(input w, input [11:0] a, input [31:0] v,
        input [32:0] e, input t);
        if (!w)
            exq.push_back(e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'h1;
        pwm_toggle <= t;
        @(posedge pclk);
        pwm_toggle <= 1'h0;
        while (!pready)
            @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, exq.pop_front());
        n1 += counter_one_preset;
        n2 += counter_two_preset;
        rnd <= lfsr(rnd);
        {cnt_wr_req, crr_wr_req, pnd_wr_req} <= rnd[2:0];
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h018, 32'h0, 33'h0, 1'h0);
        apb(1'h1, 12'h01c, 32'hffffffff, 33'h0, 1'h0);
        apb(1'h0, 12'h01c, 32'h0, {1'h1, 32'h0}, 1'h0);
        apb(1'h0, 12'h018, 32'h0, 33'h0, 1'h0);
        repeat (3)
        begin
            d = {4{rnd}} & ~32'h40;
            apb(1'h1, 12'h018, d, 33'h0, 1'h0);
            apb(1'h0, 12'h018, 32'h0, {1'h0, d & 32'h1ff}, 1'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1'h1, 12'h018, 32'h80 | (i[2] << 8) | i[1:0], 33'h0, 1'h0);
            repeat (2) @(posedge pclk);
            chk(sub_mode, i[1:0] == 0 ? i[2] : i[1:0] + 1);
        end
        foreach (cfg[k])
        begin
            apb(1'h1, 12'h018, {23'h0, cfg[k]}, 33'h0, 1'h0);
            repeat (2) @(posedge pclk);
            n1 = 0;
            n2 = 0;
            for (int j = 0; j < 4; j++)
            begin
                fa <= j < 2;
                fb <= j >= 2;
                @(posedge pclk);
                fa <= 1'h0;
                fb <= 1'h0;
                repeat (7) @(posedge pclk);
            end
            chk({n1[1:0], n2[1:0]}, ep[k]);
        end
        apb(1'h1, 12'h018, 32'h90, 33'h0, 1'h0);
        pwm_level <= 1'h1;
        repeat (3) @(posedge pclk);
        chk({timer_pin_a_oe, timer_pin_a_out}, 2'h3);
        pwm_level <= 1'h0;
        apb(1'h1, 12'h018, 32'h90, 33'h0, 1'h1);
        apb(1'h0, 12'h018, 32'h0, 33'h090, 1'h0);
        @(posedge pclk);
        pwm_toggle <= 1'h1;
        @(posedge pclk);
        pwm_toggle <= 1'h0;
        apb(1'h0, 12'h018, 32'h0, 33'h0d0, 1'h0);
        apb(1'h1, 12'h018, 32'h50, 33'h0, 1'h0);
        repeat (2) @(posedge pclk);
        chk({counter_clk_en, timer_pin_a_oe}, 2'h0);
        stop_test();
    end
endmodule
`default_nettype wire
